// file: hw/sea_pkg.sv
// Shared constants for the serial EEPROM access logic and its bus master
package sea_pkg;
    // ------------------------------------------------------------
    // Array and protocol
    // ------------------------------------------------------------
    localparam logic [3:0] DEV_CODE         = 4'hA;
    localparam int         ADDR_W           = 14;
    localparam int         MEM_DEPTH        = 16384;
    localparam int         PAGE_W           = 6;
    localparam int         PAGE_BYTES       = 64;
    localparam int         WRITE_CYCLES_DEF = 2000;
    localparam logic [3:0] BYTE_BITS        = 4'h8;

    // ------------------------------------------------------------
    // Master timing and register map
    // ------------------------------------------------------------
    localparam int         SCL_QUARTER    = 8;
    localparam logic [7:0] REG_CMD        = 8'h00;
    localparam logic [7:0] REG_ADDR       = 8'h04;
    localparam logic [7:0] REG_WDATA      = 8'h08;
    localparam logic [7:0] REG_STATUS     = 8'h0C;
    localparam int         CMD_OP_LSB     = 0;
    localparam int         CMD_SEL_LSB    = 4;
    localparam int         STAT_BUSY      = 0;
    localparam int         STAT_NACK      = 1;
    localparam int         STAT_RDATA_LSB = 8;

    // Operations and link tokens
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ  = 2'h1;
    localparam logic [1:0] OP_POLL  = 2'h2;
    localparam logic [2:0] K_START  = 3'h0;
    localparam logic [2:0] K_TX     = 3'h1;
    localparam logic [2:0] K_RX     = 3'h2;
    localparam logic [2:0] K_STOP   = 3'h3;
    localparam logic [2:0] K_END    = 3'h4;
endpackage : sea_pkg

// file: hw/sea_link_if.sv
// Two-wire link between the bus master and the EEPROM device
`timescale 1ns/10ps
interface sea_link_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic sda;

    // Wired-AND open drain line with pull-up
    assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe_n, input sda);
    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface : sea_link_if

// file: hw/sea_eeprom_dev.sv
// EEPROM device end: two-wire slave, page buffer, self-timed write, reads
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module sea_eeprom_dev #(
    parameter int WRITE_CYCLES = sea_pkg::WRITE_CYCLES_DEF
) (
    input  logic  clk,
    input  logic  rst,
    sea_link_if.dev link,
    input  logic  select_pin_0,
    input  logic  select_pin_1,
    input  logic  select_pin_2,
    input  logic  write_protect,
    output logic  write_busy
);
    typedef enum {
        ST_IDLE, ST_CTRL, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_MACK, ST_WRITE
    } sea_dev_state_e;

    sea_dev_state_e state;
    logic [1:0]     scl_s;
    logic [1:0]     sda_s;
    logic           scl_d;
    logic           sda_d;
    logic [2:0]     sel_s1;
    logic [2:0]     sel_s2;
    logic           wp_s1;
    logic           wp_s2;
    logic [3:0]     bits;
    logic [7:0]     shreg;
    logic [7:0]     tx;
    logic [7:0]     hi_byte;
    logic           ack_phase;
    logic           pull;
    logic           has_data;
    logic [13:0]    ptr;
    logic [7:0]     page;
    logic [31:0]    wcount;
    logic [63:0]    mask;
    logic [7:0]     pbuf [0:sea_pkg::PAGE_BYTES-1];
    logic [7:0]     mem  [0:sea_pkg::MEM_DEPTH-1];
    logic           scl_rise;
    logic           scl_fall;
    logic           start_ev;
    logic           stop_ev;
    logic           byte_done;
    logic           ctrl_match;
    logic           write_done;
    logic [5:0]     cidx;

    // ------------------------------------------------------------
    // Pin synchronisers and line events
    // ------------------------------------------------------------
    // Third stage only feeds edge detection, never the first flop
    always_ff @(posedge clk) begin
        scl_s  <= {scl_s[0], link.scl};
        sda_s  <= {sda_s[0], link.sda};
        scl_d  <= scl_s[1];
        sda_d  <= sda_s[1];
        sel_s1 <= {select_pin_2, select_pin_1, select_pin_0};
        sel_s2 <= sel_s1;
        wp_s1  <= write_protect;
        wp_s2  <= wp_s1;
    end

    assign scl_rise   = scl_s[1] & ~scl_d;
    assign scl_fall   = ~scl_s[1] & scl_d;
    assign start_ev   = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign stop_ev    = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    assign byte_done  = scl_fall & ~ack_phase & (bits == sea_pkg::BYTE_BITS);
    assign ctrl_match = (shreg[7:4] == sea_pkg::DEV_CODE) && (shreg[3:1] == sel_s2);
    assign write_done = (wcount == 32'(WRITE_CYCLES - 1));
    assign cidx       = wcount[5:0];

    // ------------------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------------------
    // Start and Stop win over bit handling; write cycle ignores all
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= ST_IDLE;
            bits      <= 4'h0;
            shreg     <= 8'h00;
            tx        <= 8'h00;
            hi_byte   <= 8'h00;
            ack_phase <= 1'b0;
            pull      <= 1'b0;
            has_data  <= 1'b0;
            ptr       <= 14'h0000;
            page      <= 8'h00;
        end else if (state == ST_WRITE) begin
            pull     <= 1'b0;
            has_data <= 1'b0;
            if (write_done) begin
                state <= ST_IDLE;
            end
        end else if (start_ev) begin
            state     <= ST_CTRL;
            bits      <= 4'h0;
            ack_phase <= 1'b0;
            pull      <= 1'b0;
            has_data  <= 1'b0;
        end else if (stop_ev) begin
            pull      <= 1'b0;
            ack_phase <= 1'b0;
            has_data  <= 1'b0;
            // Protect level taken only here, held by the state
            if (has_data && !wp_s2) begin
                state <= ST_WRITE;
                page  <= ptr[13:6];
            end else begin
                state <= ST_IDLE;
            end
        end else begin
            case (state)
                ST_CTRL, ST_AHI, ST_ALO, ST_WDATA: begin
                    if (scl_rise && !ack_phase) begin
                        shreg <= {shreg[6:0], sda_s[1]};
                        bits  <= bits + 4'h1;
                    end else if (scl_fall && ack_phase) begin
                        ack_phase <= 1'b0;
                        pull      <= 1'b0;
                        bits      <= 4'h0;
                    end else if (byte_done) begin
                        ack_phase <= 1'b1;
                        pull      <= 1'b1;
                        bits      <= 4'h0;
                        if (state == ST_CTRL) begin
                            if (!ctrl_match) begin
                                ack_phase <= 1'b0;
                                pull      <= 1'b0;
                                state     <= ST_IDLE;
                            end else if (shreg[0]) begin
                                tx    <= mem[ptr];
                                state <= ST_RDATA;
                            end else begin
                                state <= ST_AHI;
                            end
                        end else if (state == ST_AHI) begin
                            hi_byte <= shreg;
                            state   <= ST_ALO;
                        end else if (state == ST_ALO) begin
                            ptr   <= {hi_byte[5:0], shreg};
                            state <= ST_WDATA;
                        end else begin
                            ptr[5:0] <= ptr[5:0] + 6'h01;
                            has_data <= 1'b1;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall && ack_phase) begin
                        ack_phase <= 1'b0;
                        pull      <= ~tx[7];
                        bits      <= 4'h0;
                    end else if (scl_rise) begin
                        bits <= bits + 4'h1;
                    end else if (scl_fall) begin
                        if (bits == sea_pkg::BYTE_BITS) begin
                            pull  <= 1'b0;
                            state <= ST_MACK;
                            ptr   <= ptr + 14'h0001;
                        end else begin
                            pull <= ~tx[6];
                            tx   <= {tx[6:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (!sda_s[1]) begin
                            tx        <= mem[ptr];
                            ack_phase <= 1'b1;
                            state     <= ST_RDATA;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_IDLE: begin
                    pull <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Page buffer and written-byte mask
    // ------------------------------------------------------------
    // Late bytes land on the same wrapped slot, replacing older ones
    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= 64'h0;
        end else if (state == ST_ALO && byte_done) begin
            mask <= 64'h0;
        end else if (state == ST_WDATA && byte_done && !start_ev && !stop_ev) begin
            pbuf[ptr[5:0]] <= shreg;
            mask[ptr[5:0]] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Self-timed write cycle
    // ------------------------------------------------------------
    // Cycle counter; WRITE_CYCLES must cover the 64-byte sweep
    always_ff @(posedge clk) begin
        if (rst || state != ST_WRITE) begin
            wcount <= 32'h0;
        end else begin
            wcount <= wcount + 32'h1;
        end
    end

    // Whole page swept, unmasked bytes refreshed with old contents
    always_ff @(posedge clk) begin
        if (state == ST_WRITE && wcount < sea_pkg::PAGE_BYTES) begin
            mem[{page, cidx}] <= mask[cidx] ? pbuf[cidx] : mem[{page, cidx}];
        end
    end

    // Open drain: only ever pulls low
    assign link.dev_sda_o    = 1'b0;
    assign link.dev_sda_oe_n = ~pull;
    assign write_busy        = (state == ST_WRITE);
endmodule : sea_eeprom_dev

// file: hw/sea_bus_master.sv
// Bus master end: APB command registers driving the two-wire link
`timescale 1ns/10ps
module sea_bus_master (
    input  logic        clk,
    input  logic        rst,
    input  logic [7:0]  paddr,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    sea_link_if.host    link
);
    logic [1:0] cmd_op;
    logic [2:0] cmd_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       busy;
    logic       nack;
    logic [3:0] step;
    logic [3:0] bitn;
    logic [1:0] q;
    logic [7:0] qcnt;
    logic [1:0] sda_s;
    logic       scl_r;
    logic       sda_rel;
    logic [5:0] tok;
    logic [2:0] kind;
    logic [7:0] cur_byte;
    logic       tick;
    logic       next_scl;
    logic       next_sda;
    logic       apb_wr;

    // ------------------------------------------------------------
    // Token table for each operation
    // ------------------------------------------------------------
    function automatic logic [5:0] sea_token(input logic [1:0] op, input logic [3:0] st);
        logic [5:0] t;
        t = {sea_pkg::K_END, 3'h0};
        case ({op, st})
            {sea_pkg::OP_WRITE, 4'h0}, {sea_pkg::OP_READ, 4'h0}, {sea_pkg::OP_POLL, 4'h0},
            {sea_pkg::OP_READ, 4'h4}: t = {sea_pkg::K_START, 3'h0};
            {sea_pkg::OP_WRITE, 4'h1}, {sea_pkg::OP_READ, 4'h1}, {sea_pkg::OP_POLL, 4'h1}:
                t = {sea_pkg::K_TX, 3'h0};
            {sea_pkg::OP_WRITE, 4'h2}, {sea_pkg::OP_READ, 4'h2}: t = {sea_pkg::K_TX, 3'h1};
            {sea_pkg::OP_WRITE, 4'h3}, {sea_pkg::OP_READ, 4'h3}: t = {sea_pkg::K_TX, 3'h2};
            {sea_pkg::OP_WRITE, 4'h4}: t = {sea_pkg::K_TX, 3'h3};
            {sea_pkg::OP_READ, 4'h5}: t = {sea_pkg::K_TX, 3'h4};
            {sea_pkg::OP_READ, 4'h6}: t = {sea_pkg::K_RX, 3'h0};
            {sea_pkg::OP_WRITE, 4'h5}, {sea_pkg::OP_READ, 4'h7}, {sea_pkg::OP_POLL, 4'h2}:
                t = {sea_pkg::K_STOP, 3'h0};
            default: t = {sea_pkg::K_END, 3'h0};
        endcase
        return t;
    endfunction : sea_token

    assign tok  = sea_token(cmd_op, step);
    assign kind = tok[5:3];
    assign tick = (qcnt == 8'(sea_pkg::SCL_QUARTER - 1));

    // Byte to shift out for the current token
    always_comb begin
        case (tok[2:0])
            3'h0:    cur_byte = {sea_pkg::DEV_CODE, cmd_sel, 1'b0};
            3'h1:    cur_byte = addr[15:8];
            3'h2:    cur_byte = addr[7:0];
            3'h3:    cur_byte = wdata;
            default: cur_byte = {sea_pkg::DEV_CODE, cmd_sel, 1'b1};
        endcase
    end

    // Line levels per quarter; Start and Stop move SDA while SCL high
    always_comb begin
        next_scl = 1'b1;
        next_sda = 1'b1;
        if (busy) begin
            case (kind)
                sea_pkg::K_START: begin
                    next_scl = (q == 2'h1) || (q == 2'h2);
                    next_sda = (q < 2'h2);
                end
                sea_pkg::K_TX: begin
                    next_scl = (q == 2'h1) || (q == 2'h2);
                    next_sda = (bitn < sea_pkg::BYTE_BITS) ? cur_byte[3'h7 - bitn[2:0]] : 1'b1;
                end
                sea_pkg::K_RX: begin
                    next_scl = (q == 2'h1) || (q == 2'h2);
                    next_sda = 1'b1;
                end
                sea_pkg::K_STOP: begin
                    next_scl = (q != 2'h0);
                    next_sda = (q >= 2'h2);
                end
                default: begin
                    next_scl = 1'b1;
                    next_sda = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link engine
    // ------------------------------------------------------------
    // Line read back is treated as a pin and synchronised
    always_ff @(posedge clk) begin
        sda_s   <= {sda_s[0], link.sda};
        scl_r   <= rst ? 1'b1 : next_scl;
        sda_rel <= rst ? 1'b1 : next_sda;
    end

    assign apb_wr = psel & penable & pwrite;

    // One operation at a time; a new command while busy is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            busy  <= 1'b0;
            nack  <= 1'b0;
            rdata <= 8'h00;
            step  <= 4'h0;
            bitn  <= 4'h0;
            q     <= 2'h0;
            qcnt  <= 8'h00;
        end else if (!busy) begin
            if (apb_wr && paddr == sea_pkg::REG_CMD) begin
                busy <= 1'b1;
                nack <= 1'b0;
                step <= 4'h0;
                bitn <= 4'h0;
                q    <= 2'h0;
                qcnt <= 8'h00;
            end
        end else if (kind == sea_pkg::K_END) begin
            busy <= 1'b0;
        end else begin
            qcnt <= tick ? 8'h00 : qcnt + 8'h01;
            if (tick) begin
                q <= q + 2'h1;
                if (q == 2'h2 && kind == sea_pkg::K_RX && bitn < sea_pkg::BYTE_BITS) begin
                    rdata <= {rdata[6:0], sda_s[1]};
                end
                if (q == 2'h2 && kind == sea_pkg::K_TX && bitn == sea_pkg::BYTE_BITS && sda_s[1]) begin
                    nack <= 1'b1;
                end
                if (q == 2'h3) begin
                    if ((kind == sea_pkg::K_TX || kind == sea_pkg::K_RX) && bitn != sea_pkg::BYTE_BITS) begin
                        bitn <= bitn + 4'h1;
                    end else begin
                        bitn <= 4'h0;
                        // Missing acknowledge skips straight to Stop
                        if (kind == sea_pkg::K_TX && nack) begin
                            step <= (cmd_op == sea_pkg::OP_POLL) ? 4'h2 :
                                    (cmd_op == sea_pkg::OP_READ) ? 4'h7 : 4'h5;
                        end else begin
                            step <= step + 4'h1;
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_op  <= sea_pkg::OP_WRITE;
            cmd_sel <= 3'h0;
            addr    <= 16'h0000;
            wdata   <= 8'h00;
        end else if (apb_wr) begin
            if (paddr == sea_pkg::REG_CMD && !busy) begin
                cmd_op  <= pwdata[sea_pkg::CMD_OP_LSB +: 2];
                cmd_sel <= pwdata[sea_pkg::CMD_SEL_LSB +: 3];
            end
            if (paddr == sea_pkg::REG_ADDR && !busy) begin
                addr <= pwdata[15:0];
            end
            if (paddr == sea_pkg::REG_WDATA && !busy) begin
                wdata <= pwdata[7:0];
            end
        end
    end

    // Read data captured in setup so the access phase needs no wait
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0;
            case (paddr)
                sea_pkg::REG_CMD: begin
                    prdata[sea_pkg::CMD_OP_LSB +: 2]  <= cmd_op;
                    prdata[sea_pkg::CMD_SEL_LSB +: 3] <= cmd_sel;
                end
                sea_pkg::REG_ADDR:  prdata[15:0] <= addr;
                sea_pkg::REG_WDATA: prdata[7:0]  <= wdata;
                sea_pkg::REG_STATUS: begin
                    prdata[sea_pkg::STAT_BUSY]          <= busy;
                    prdata[sea_pkg::STAT_NACK]          <= nack;
                    prdata[sea_pkg::STAT_RDATA_LSB +: 8] <= rdata;
                end
                default: prdata <= 32'h0;
            endcase
        end
    end

    assign pready             = 1'b1;
    assign pslverr            = 1'b0;
    assign link.scl           = scl_r;
    assign link.host_sda_o    = 1'b0;
    assign link.host_sda_oe_n = sda_rel;
endmodule : sea_bus_master

// file: verif/sea_link_chk.sv
// Assertions on the two-wire link between the master and the device
`timescale 1ns/10ps
module sea_link_chk #(
    parameter int WRITE_CYCLES = 600
) (
    input logic clk,
    input logic rst,
    input logic scl,
    input logic sda,
    input logic host_sda_o,
    input logic host_sda_oe_n,
    input logic dev_sda_o,
    input logic dev_sda_oe_n,
    input logic write_busy,
    input logic write_protect
);
    logic        scl_q;
    logic        sda_q;
    logic        stop_seen;
    logic [7:0]  stop_age;
    logic [15:0] busy_cnt;

    // Previous line levels, used to spot a Stop
    always_ff @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
    end
    assign stop_seen = scl & scl_q & sda & ~sda_q;

    // Cycles since the last Stop, saturating so it never wraps
    always_ff @(posedge clk) begin
        if (rst || stop_seen) stop_age <= 8'h00;
        else if (stop_age != 8'hFF) stop_age <= stop_age + 8'h01;
    end

    // Length of the current write cycle
    always_ff @(posedge clk) begin
        if (rst || !write_busy) busy_cnt <= 16'h0000;
        else busy_cnt <= busy_cnt + 16'h0001;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    dev_pull_a: assert property (!dev_sda_oe_n |-> !dev_sda_o)
        else $error("device drives SDA high");
    host_pull_a: assert property (!host_sda_oe_n |-> !host_sda_o)
        else $error("master drives SDA high");
    busy_quiet_a: assert property (write_busy |-> dev_sda_oe_n)
        else $error("device pulls SDA during write cycle");
    dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device moves SDA while SCL high");
    scl_quarter_a: assert property ($changed(scl) |=> $stable(scl) [*7])
        else $error("SCL level shorter than a quarter");
    busy_stop_a: assert property ($rose(write_busy) |-> stop_age <= 8'h08)
        else $error("write cycle not started by a Stop");
    wp_block_a: assert property ($rose(write_busy) |-> !$past(write_protect, 6))
        else $error("write cycle started while protected");
    busy_len_a: assert property ($fell(write_busy) |->
        busy_cnt >= 16'(WRITE_CYCLES - 1) && busy_cnt <= 16'(WRITE_CYCLES + 1))
        else $error("write cycle length wrong");
    stop_release_a: assert property (stop_seen |=> dev_sda_oe_n [*4])
        else $error("device holds SDA after Stop");

    busy_c: cover property ($fell(write_busy));
    ack_c: cover property ($fell(dev_sda_oe_n));
    stop_c: cover property (stop_seen);
endmodule : sea_link_chk

// file: verif/serial_eeprom_access_logic_tb.sv
// Testbench: APB commands through the master to the device
`timescale 1ns/10ps
module serial_eeprom_access_logic_tb;
    localparam int WC = 600;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        wp = 1'b0;
    logic        busy;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          num_checks = 0;
    sea_link_if  link ();

    // 250 MHz clock
    always #2 clk = ~clk;

    // Select pins strapped to 101, long write cycle so a poll can be refused
    sea_eeprom_dev #(.WRITE_CYCLES(WC)) i_sea_eeprom_dev (.clk(clk), .rst(rst), .link(link), .select_pin_0(1'b1),
        .select_pin_1(1'b0), .select_pin_2(1'b1), .write_protect(wp), .write_busy(busy));
    sea_bus_master i_sea_bus_master (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .link(link));
    sea_link_chk #(.WRITE_CYCLES(WC)) i_sea_link_chk (.clk(clk), .rst(rst), .scl(link.scl), .sda(link.sda),
        .host_sda_o(link.host_sda_o), .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
        .dev_sda_oe_n(link.dev_sda_oe_n), .write_busy(busy), .write_protect(wp));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; read data taken at the edge that samples pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            stop_test();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Launch an operation and read status until the master is idle
    task automatic run(input logic [1:0] op, input logic [2:0] sel);
        int n;
        apb(sea_pkg::REG_CMD, 1'b1, {25'h0, sel, 2'h0, op});
        n = 0;
        do begin
            apb(sea_pkg::REG_STATUS, 1'b0, 32'h0);
            n++;
        end while (rd[sea_pkg::STAT_BUSY] !== 1'b0 && n < 1500);
        if (n >= 1500) begin
            error_cnt++;
            stop_test();
        end
    endtask : run

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [2:0] sel);
        apb(sea_pkg::REG_ADDR, 1'b1, {16'h0, a});
        apb(sea_pkg::REG_WDATA, 1'b1, {24'h0, d});
        run(sea_pkg::OP_WRITE, sel);
    endtask : wr

    // Read one byte and compare data and acknowledge together
    task automatic rdb(input logic [15:0] a, input logic [7:0] d);
        apb(sea_pkg::REG_ADDR, 1'b1, {16'h0, a});
        run(sea_pkg::OP_READ, 3'h5);
        chk(rd & 32'h0000FF02, {16'h0, d, 8'h00});
    endtask : rdb

    // Repeat the poll until the device answers again
    task automatic poll();
        int n;
        n = 0;
        do begin
            run(sea_pkg::OP_POLL, 3'h5);
            n++;
        end while (rd[sea_pkg::STAT_NACK] !== 1'b0 && n < 20);
        chk(rd & 32'h2, 32'h0);
    endtask : poll

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        apb(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wr(16'hC123, 8'h5A, 3'h5);
        chk(rd & 32'h2, 32'h0);
        run(sea_pkg::OP_POLL, 3'h5);
        chk(rd & 32'h2, 32'h2);
        poll();
        rdb(16'h0123, 8'h5A);
        wr(16'h0124, 8'h3C, 3'h5);
        poll();
        rdb(16'h0123, 8'h5A);
        rdb(16'h0124, 8'h3C);
        wr(16'h0123, 8'hFF, 3'h3);
        chk(rd & 32'h2, 32'h2);
        wp <= 1'b1;
        wr(16'h0123, 8'hA5, 3'h5);
        chk(rd & 32'h2, 32'h0);
        run(sea_pkg::OP_POLL, 3'h5);
        chk(rd & 32'h2, 32'h0);
        wp <= 1'b0;
        rdb(16'h0123, 8'h5A);
        stop_test();
    end
endmodule : serial_eeprom_access_logic_tb
